// ===== hcc_cmd_status.v
// heater controller command interpreter and status reporting over axi4-lite
`timescale 1ns/1ps
// Overview of operation
// (R1) version kept in nonvolatile store across power loss
// (R2) send address 11 returns stored version
// (R3) factory version defaults to code one
// (R4) selected set point clamped to version limit
// (R5) analog full scale 300 or 500 by version
// (R6) master runs zero calibration after version change
// (R7) reset command clears the alarm state
// (R8) reset starts 500ms init, blocks new heating
// (R9) contactor energized after 50ms raises alarm
// (R10) actual query: whole degrees, msb sign flag
// (R11) send 0..3 return stored set points
// (R12) send 4 returns actual temperature
// (R13) send 5 returns full status word
// (R14) send 6 and 7 return BCD serial parts
// (R15) send 8 returns calibration temperature
// (R16) send 10 returns monitoring band width
// (R17) send 11 returns version code
// (R18) status word sent only on request
// (R19) status bits 0..4: setpoint, mode, band, alarm
// (R20) status bits 5,6 calibration; 8..11 alarm code
// (R21) acknowledgment built after each start or stop
// (R22) acknowledgment word bit layout as documented
// (R23) version codes decode to alloy and limit; only the limit is decoded here
// (R24) in-band flag clears when control mode ends
// (R25) unassigned status and ack bits are zero
`include "hcc_consts.vh"
module hcc_cmd_status #(
   parameter INIT_CYC = `HCC_INIT_MS * `HCC_CLK_KHZ, // init run length
   parameter LATE_CYC = `HCC_CONTACT_MS * `HCC_CLK_KHZ, // contactor deadline
   parameter TICK_CYC = `HCC_TICK_MS * `HCC_CLK_KHZ, // heating time unit
   parameter [23:0] SERIAL_BCD = 24'h123456 // arbitrary serial value
)(
   // clock and reset
   input wire mclk,
   input wire nrst,
   // axi4-lite write address and data
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // control loop side
   input wire signed [9:0] actualTemp,
   input wire tempInBand,
   input wire [3:0] loopAlarmCode,
   input wire calBlocked,
   input wire calRunning,
   input wire loopContactor,
   // nonvolatile version store
   input wire nvValid,
   input wire [2:0] nvVersion,
   output reg nvWrite,
   output reg [2:0] nvData,
   // to control loop
   output reg heatOn,
   output reg [8:0] activeSetpoint,
   output reg [8:0] fullScale,
   output reg calRequest,
   output reg ackPulse
);
   // axi write side state
   reg awHeld_q; // address captured
   reg wHeld_q; // data captured
   reg [7:0] awAddr_q;
   reg [31:0] wData_q;
   // stored settings
   reg [8:0] setpoint_q [0:3]; // set point memory
   reg [2:0] version_q;
   reg [5:0] calTemp_q;
   reg [4:0] bandWidth_q;
   reg nvLoaded_q; // one-shot load after reset
   // command and mode state
   reg [19:0] cmdWord_q; // last command written
   reg [3:0] queryAddr_q;
   reg [15:0] resp_q;
   reg [15:0] ackWord_q;
   reg ackPending_q;
   reg [1:0] spSel_q; // last set point used
   reg [25:0] heatCnt_q; // remaining heat cycles
   reg [23:0] initCnt_q; // init run countdown
   reg [23:0] lateCnt_q; // contactor deadline countdown
   reg lateArmed_q;
   reg lateAlarm_q;
   reg [3:0] alarmCode_q;
   reg contactorUsed_q;
   reg cmdRefused_q;
   // contactor synchroniser
   reg contSync1_q;
   reg contSync2_q;
   // decoded helpers
   wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
   wire cmdStrobe = doWrite && awAddr_q == `HCC_REG_CMD;
   wire [3:0] rxAddr = wData_q[19:16];
   wire [15:0] rxVal = wData_q[15:0];
   wire alarmActive = alarmCode_q != 4'h0;
   wire initBusy = initCnt_q != 24'h0;
   wire controlActive = heatCnt_q != 26'h0;
   wire inBandFlag = tempInBand & controlActive; // [R24]
   reg [8:0] tMax;
   reg [15:0] statusWord;
   reg [15:0] actualWord;
   reg [15:0] ackNext;
   reg [15:0] txVal;
   wire [9:0] tempMag = actualTemp[9] ? -actualTemp : actualTemp;
   wire isStart = rxAddr == `HCC_RX_START;
   wire isStop = rxVal[7:0] < `HCC_HEAT_MIN;
   wire startOk = ~alarmActive & ~calRunning & ~initBusy; // [R8]
   wire isReset = rxAddr == `HCC_RX_FUNC && rxVal == `HCC_FN_RESET;
   wire [31:0] heatProd = rxVal[7:0] * TICK_CYC;

   assign s_axi_awready = ~awHeld_q;
   assign s_axi_wready = ~wHeld_q;
   assign s_axi_arready = ~s_axi_rvalid;

   // version decode to temperature limit
   always @*
   begin
      case (version_q) // [R23]
         3'h0: tMax = `HCC_TMAX_200;
         3'h1: tMax = `HCC_TMAX_300;
         3'h2: tMax = `HCC_TMAX_400;
         3'h3: tMax = `HCC_TMAX_500;
         3'h4: tMax = `HCC_TMAX_200;
         default: tMax = `HCC_TMAX_300;
      endcase
   end

   // word layouts and send table
   always @*
   begin
      // sign flag in msb, magnitude below
      actualWord = {actualTemp[9], 5'h00, tempMag}; // [R10]
      // status word, unused bits zero
      statusWord = {4'h0, alarmCode_q, 1'b0, calRunning, calBlocked,
         alarmActive, inBandFlag, controlActive, spSel_q}; // [R19] [R20] [R25]
      // acknowledgment layout
      ackNext = {calBlocked, alarmActive, inBandFlag, controlActive,
         spSel_q, actualTemp[9], tempMag[8:0]}; // [R22]
      case (queryAddr_q)
         4'h0, 4'h1, 4'h2, 4'h3: txVal = {7'h00, setpoint_q[queryAddr_q[1:0]]}; // [R11]
         `HCC_TX_ACTUAL: txVal = actualWord; // [R12]
         `HCC_TX_STATUS: txVal = statusWord; // [R13] [R18]
         `HCC_TX_SER_HI: txVal = {4'h0, SERIAL_BCD[23:20], SERIAL_BCD[19:12]}; // [R14]
         `HCC_TX_SER_LO: txVal = {4'h0, SERIAL_BCD[11:8], SERIAL_BCD[7:0]}; // [R14]
         `HCC_TX_CALT: txVal = {10'h000, calTemp_q}; // [R15]
         `HCC_TX_ACK: txVal = ackWord_q;
         `HCC_TX_BAND: txVal = {11'h000, bandWidth_q}; // [R16]
         `HCC_TX_VER: txVal = {13'h0000, version_q}; // [R2] [R17]
         default: txVal = 16'h0000;
      endcase
   end

   // contactor pin synchroniser
   always @(posedge mclk)
   begin
      if (!nrst)
      begin
         contSync1_q <= 1'b0;
         contSync2_q <= 1'b0;
      end
      else
      begin
         contSync1_q <= loopContactor;
         contSync2_q <= contSync1_q;
      end
   end

   // axi write channel capture and response
   always @(posedge mclk)
   begin
      if (!nrst)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `HCC_RESP_OKAY;
      end
      else
      begin
         // take address and data in either order
         if (s_axi_awvalid && !awHeld_q)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeld_q)
         begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
         end
         if (doWrite)
         begin
            s_axi_bvalid <= 1'b1;
            case (awAddr_q)
               `HCC_REG_CMD, `HCC_REG_QUERY, `HCC_REG_CTRL: s_axi_bresp <= `HCC_RESP_OKAY;
               default: s_axi_bresp <= `HCC_RESP_SLVERR;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            // release holds once response taken
            s_axi_bvalid <= 1'b0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
         end
      end
   end

   // axi read channel
   always @(posedge mclk)
   begin
      if (!nrst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `HCC_RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `HCC_RESP_OKAY;
         case (s_axi_araddr)
            `HCC_REG_CMD: s_axi_rdata <= {12'h000, cmdWord_q};
            `HCC_REG_QUERY: s_axi_rdata <= {28'h0, queryAddr_q};
            `HCC_REG_RESP: s_axi_rdata <= {16'h0, resp_q};
            `HCC_REG_ACK: s_axi_rdata <= {16'h0, ackWord_q};
            `HCC_REG_STAT: s_axi_rdata <= {28'h0, cmdRefused_q, controlActive,
               initBusy, ackPending_q};
            `HCC_REG_CTRL: s_axi_rdata <= {31'h0, contactorUsed_q};
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `HCC_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // set point memory per entry
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : spMem
         always @(posedge mclk)
         begin
            if (!nrst)
               setpoint_q[gi] <= `HCC_SP_DEF;
            else if (cmdStrobe && rxAddr == gi && rxVal <= {7'h00, tMax})
               setpoint_q[gi] <= rxVal[8:0]; // over-limit writes rejected
         end
      end
   endgenerate

   // settings, version store and query
   always @(posedge mclk)
   begin
      if (!nrst)
      begin
         version_q <= `HCC_VER_DEF; // [R3]
         calTemp_q <= `HCC_CALT_DEF;
         bandWidth_q <= `HCC_BAND_DEF;
         nvLoaded_q <= 1'b0;
         nvWrite <= 1'b0;
         nvData <= `HCC_VER_DEF;
         cmdWord_q <= 20'h0;
         queryAddr_q <= 4'h0;
         resp_q <= 16'h0;
         contactorUsed_q <= 1'b0;
      end
      else
      begin
         nvWrite <= 1'b0;
         nvLoaded_q <= 1'b1;
         // restore retained version after reset release
         if (!nvLoaded_q && nvValid && nvVersion <= `HCC_VER_MAX)
            version_q <= nvVersion; // [R1]
         if (cmdStrobe)
         begin
            cmdWord_q <= wData_q[19:0];
            case (rxAddr)
               `HCC_RX_CALT: if (rxVal <= {10'h000, `HCC_CALT_MAX})
                  calTemp_q <= rxVal[5:0];
               `HCC_RX_BAND: if (rxVal >= {11'h000, `HCC_BAND_MIN} &&
                     rxVal <= {11'h000, `HCC_BAND_MAX})
                  bandWidth_q <= rxVal[4:0];
               `HCC_RX_VER: if (rxVal <= {13'h0000, `HCC_VER_MAX})
               begin
                  version_q <= rxVal[2:0];
                  nvWrite <= 1'b1; // [R1]
                  nvData <= rxVal[2:0];
               end
               default: ;
            endcase
         end
         // query address latched on write, answer refreshed every cycle
         if (doWrite && awAddr_q == `HCC_REG_QUERY)
            queryAddr_q <= wData_q[3:0];
         resp_q <= txVal;
         if (doWrite && awAddr_q == `HCC_REG_CTRL)
            contactorUsed_q <= wData_q[0];
      end
   end

   // heating, reset run, alarm and acknowledgment
   always @(posedge mclk)
   begin
      if (!nrst)
      begin
         heatCnt_q <= 26'h0;
         initCnt_q <= 24'h0;
         lateCnt_q <= 24'h0;
         lateArmed_q <= 1'b0;
         lateAlarm_q <= 1'b0;
         alarmCode_q <= 4'h0;
         spSel_q <= 2'h0;
         ackWord_q <= 16'h0;
         ackPending_q <= 1'b0;
         ackPulse <= 1'b0;
         calRequest <= 1'b0;
         cmdRefused_q <= 1'b0;
      end
      else
      begin
         ackPulse <= 1'b0;
         calRequest <= 1'b0;
         if (heatCnt_q != 26'h0)
            heatCnt_q <= heatCnt_q - 26'h1;
         if (initBusy)
            initCnt_q <= initCnt_q - 24'h1;
         // contactor deadline after reset
         if (lateArmed_q)
         begin
            if (contSync2_q)
               lateArmed_q <= 1'b0;
            else if (lateCnt_q == 24'h0)
            begin
               lateArmed_q <= 1'b0;
               lateAlarm_q <= 1'b1; // [R9]
            end
            else
               lateCnt_q <= lateCnt_q - 24'h1;
         end
         // alarm code latches until reset command
         if (cmdStrobe && isReset)
         begin
            alarmCode_q <= 4'h0; // [R7]
            lateAlarm_q <= 1'b0;
            heatCnt_q <= 26'h0;
            initCnt_q <= INIT_CYC[23:0]; // [R8]
            lateCnt_q <= LATE_CYC[23:0];
            lateArmed_q <= contactorUsed_q;
         end
         else if (loopAlarmCode != 4'h0)
            alarmCode_q <= loopAlarmCode;
         else if (lateAlarm_q)
            alarmCode_q <= `HCC_ALM_LATE;
         if (cmdStrobe && rxAddr == `HCC_RX_FUNC && rxVal == `HCC_FN_AUTO_ZERO_CALIBRATION)
            calRequest <= 1'b1;
         // start or stop, always acknowledged
         if (cmdStrobe && isStart)
         begin
            ackWord_q <= ackNext; // [R21]
            ackPulse <= 1'b1;
            if (isStop)
               heatCnt_q <= 26'h0;
            else if (startOk)
            begin
               heatCnt_q <= heatProd[25:0];
               spSel_q <= rxVal[9:8];
            end
            else
               cmdRefused_q <= 1'b1;
         end
         // software read of ack clears pending; new ack wins
         if (cmdStrobe && isStart)
            ackPending_q <= 1'b1;
         else if (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == `HCC_REG_ACK)
         begin
            ackPending_q <= 1'b0;
            cmdRefused_q <= 1'b0;
         end
      end
   end

   // loop outputs: clamped set point and scale
   always @(posedge mclk)
   begin
      if (!nrst)
      begin
         heatOn <= 1'b0;
         activeSetpoint <= `HCC_SP_DEF;
         fullScale <= `HCC_TMAX_300;
      end
      else
      begin
         heatOn <= controlActive;
         if (setpoint_q[spSel_q] > tMax)
            activeSetpoint <= tMax; // [R4]
         else
            activeSetpoint <= setpoint_q[spSel_q];
         if (tMax == `HCC_TMAX_200 || tMax == `HCC_TMAX_300)
            fullScale <= `HCC_TMAX_300; // [R5]
         else
            fullScale <= `HCC_TMAX_500; // [R5]
      end
   end

endmodule // hcc_cmd_status

// ===== hcc_cmd_status_asserts.sv
// port assertions for the heater command block
`timescale 1ns/1ps
module hcc_chk (
   // clock and reset
   input wire mclk,
   input wire nrst,
   // bus handshakes
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // loop and store side
   input wire nvWrite,
   input wire [2:0] nvData,
   input wire heatOn,
   input wire [8:0] activeSetpoint,
   input wire [8:0] fullScale,
   input wire calRequest,
   input wire ackPulse
);
   // one clock domain, reset disables all but the reset check
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // answers stand until the master takes them
   chk_bresp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   chk_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   // scale is only ever one of two values
   chk_scale_range: assert property (
      fullScale == 9'h12c || fullScale == 9'h1f4)
      else $error("full scale out of set");
   chk_setpoint_clamp: assert property (heatOn |-> activeSetpoint <= fullScale)
      else $error("set point above limit");
   // single-cycle events
   chk_ack_pulse: assert property (ackPulse |=> !ackPulse)
      else $error("ack pulse too long");
   chk_cal_pulse: assert property (calRequest |=> !calRequest)
      else $error("calibration pulse too long");
   chk_nv_code: assert property (nvWrite |-> (nvData <= 3'h5) ##1 !nvWrite)
      else $error("bad store write");
   chk_reset_state: assert property (disable iff (1'b0)
      !nrst |=> !s_axi_bvalid && !s_axi_rvalid && !heatOn && fullScale == 9'h12c)
      else $error("reset state wrong");
endmodule // hcc_chk

bind hcc_cmd_status hcc_chk u_chk (.mclk(mclk), .nrst(nrst),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .nvWrite(nvWrite), .nvData(nvData), .heatOn(heatOn), .activeSetpoint(activeSetpoint),
   .fullScale(fullScale), .calRequest(calRequest), .ackPulse(ackPulse));

// ===== hcc_consts.vh
// constants for the heater command and status block
`ifndef HCC_CONSTS_VH
`define HCC_CONSTS_VH
// clock rate and time figures
`define HCC_CLK_KHZ 25000
`define HCC_INIT_MS 500
`define HCC_CONTACT_MS 50
`define HCC_TICK_MS 10
// register byte offsets
`define HCC_REG_CMD 8'h00
`define HCC_REG_QUERY 8'h04
`define HCC_REG_RESP 8'h08
`define HCC_REG_ACK 8'h0c
`define HCC_REG_STAT 8'h10
`define HCC_REG_CTRL 8'h14
// axi responses
`define HCC_RESP_OKAY 2'b00
`define HCC_RESP_SLVERR 2'b10
// receive addresses
`define HCC_RX_FUNC 4'h4
`define HCC_RX_START 4'h5
`define HCC_RX_CALT 4'h6
`define HCC_RX_BAND 4'h7
`define HCC_RX_VER 4'h8
// function codes at receive address 4
`define HCC_FN_AUTO_ZERO_CALIBRATION 16'h0005
`define HCC_FN_RESET 16'h000c
// send addresses
`define HCC_TX_ACTUAL 4'h4
`define HCC_TX_STATUS 4'h5
`define HCC_TX_SER_HI 4'h6
`define HCC_TX_SER_LO 4'h7
`define HCC_TX_CALT 4'h8
`define HCC_TX_ACK 4'h9
`define HCC_TX_BAND 4'ha
`define HCC_TX_VER 4'hb
// version codes, limits and defaults
`define HCC_VER_DEF 3'h1
`define HCC_VER_MAX 3'h5
`define HCC_TMAX_200 9'h0c8
`define HCC_TMAX_300 9'h12c
`define HCC_TMAX_400 9'h190
`define HCC_TMAX_500 9'h1f4
`define HCC_CALT_DEF 6'h14
`define HCC_CALT_MAX 6'h28
`define HCC_BAND_DEF 5'h0a
`define HCC_BAND_MIN 5'h03
`define HCC_BAND_MAX 5'h14
`define HCC_SP_DEF 9'h000
`define HCC_HEAT_MIN 8'h05
`define HCC_ALM_LATE 4'h7
`endif

// ===== hcc_loop_model.sv
// far side model: version store and loop contactor
`timescale 1ns/1ps
module hcc_loop_model (
   // clock
   input wire mclk,
   // version store port
   input wire nvWrite,
   input wire [2:0] nvData,
   output reg nvValid,
   output reg [2:0] nvVersion,
   // contactor drive
   input wire energize,
   output reg loopContactor
);
   // store starts blank with a junk code
   initial
   begin
      nvValid = 1'b0;
      nvVersion = 3'h7;
      loopContactor = 1'b0;
   end
   // store keeps its code across design resets
   always @(posedge mclk)
   begin
      if (nvWrite)
      begin
         nvValid <= 1'b1;
         nvVersion <= nvData;
      end
      loopContactor <= energize;
   end
endmodule // hcc_loop_model

// ===== tb_top.sv
// self-checking bench for the heater command block
`timescale 1ns/1ps
`include "hcc_consts.vh"
module tb_top;
   reg mclk = 1'b0;
   reg nrst = 1'b0;
   reg [7:0] awAddr = 8'h00, arAddr = 8'h00; // bus addresses
   reg [31:0] wData = 32'h0; // write data
   reg awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   reg [9:0] actTemp = 10'h014; // loop inputs
   reg [3:0] almCode = 4'h0;
   reg inBand = 1'b0, calBlk = 1'b0, calRun = 1'b0, energize = 1'b0;
   wire awReady, wReady, bValid, arReady, rValid, nvValid, nvWrite, heatOn, calReq;
   wire ackPulse, loopContactor;
   wire [1:0] bResp, rResp;
   wire [31:0] rData;
   wire [2:0] nvVersion, nvData;
   wire [8:0] activeSp, fullScale;
   integer n_mismatch = 0, cmp_count = 0, ackCnt = 0, calCnt = 0, i, a0;
   reg [31:0] v, d;
   reg [1:0] r;
   // short counts keep the run brief
   hcc_cmd_status #(.INIT_CYC(50), .LATE_CYC(20), .TICK_CYC(4)) DUT (.mclk(mclk), .nrst(nrst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .actualTemp(actTemp), .tempInBand(inBand), .loopAlarmCode(almCode),
      .calBlocked(calBlk), .calRunning(calRun), .loopContactor(loopContactor),
      .nvValid(nvValid), .nvVersion(nvVersion), .nvWrite(nvWrite), .nvData(nvData),
      .heatOn(heatOn), .activeSetpoint(activeSp), .fullScale(fullScale),
      .calRequest(calReq), .ackPulse(ackPulse));
   hcc_loop_model PARTNER (.mclk(mclk), .nvWrite(nvWrite), .nvData(nvData),
      .nvValid(nvValid), .nvVersion(nvVersion), .energize(energize),
      .loopContactor(loopContactor));
   // clock and event counters
   always #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      // count only known highs, so unset outputs before reset cannot poison the tallies
      if (ackPulse === 1'b1) ackCnt = ackCnt + 1;
      if (calReq === 1'b1) calCnt = calCnt + 1;
   end
   // compare and count
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   // bus write, both channels offered together
   task wr(input [7:0] a, input [31:0] dd, output [1:0] rr);
      integer n;
   begin
      @(posedge mclk);
      awAddr <= a;
      wData <= dd;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n = n + 1;
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
      end
      while (!bValid && n < 50);
      rr = bResp;
      bReady <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   end
   endtask
   // bus read
   task rd(input [7:0] a, output [31:0] dd, output [1:0] rr);
      integer n;
   begin
      @(posedge mclk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n = n + 1;
         if (arReady) arValid <= 1'b0;
      end
      while (!rValid && n < 50);
      dd = rData;
      rr = rResp;
      rReady <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   end
   endtask
   // command and query helpers
   task cmd(input [3:0] ra, input [15:0] val);
      wr(`HCC_REG_CMD, {12'h0, ra, val}, r);
   endtask
   task q(input [3:0] sa, output [31:0] vv);
   begin
      wr(`HCC_REG_QUERY, {28'h0, sa}, r);
      repeat (2) @(posedge mclk);
      rd(`HCC_REG_RESP, d, r);
      vv = {16'h0, d[15:0]};
   end
   endtask
   task t_defaults;
   begin
      q(`HCC_TX_VER, v); chk(v, 32'h1);
      chk(fullScale, 32'h12c);
      q(`HCC_TX_SER_HI, v); chk(v, 32'h0123);
      q(`HCC_TX_SER_LO, v); chk(v, 32'h0456);
      q(`HCC_TX_CALT, v); chk(v, 32'h14);
      q(`HCC_TX_BAND, v); chk(v, 32'ha);
      // stored settings take legal values and ignore out-of-range ones
      cmd(`HCC_RX_CALT, 16'h1e); cmd(`HCC_RX_CALT, 16'h29);
      q(`HCC_TX_CALT, v); chk(v, 32'h1e);
      cmd(`HCC_RX_BAND, 16'h14); cmd(`HCC_RX_BAND, 16'h2);
      q(`HCC_TX_BAND, v); chk(v, 32'h14);
      rd(8'h20, d, r); chk(r, `HCC_RESP_SLVERR);
      wr(`HCC_REG_RESP, 32'h1, r); chk(r, `HCC_RESP_SLVERR);
      $display("defaults done");
   end
   endtask
   task t_version;
   begin
      for (i = 0; i < 6; i = i + 1)
      begin
         cmd(`HCC_RX_VER, i[15:0]);
         cmd(`HCC_RX_FUNC, `HCC_FN_AUTO_ZERO_CALIBRATION);
         q(`HCC_TX_VER, v); chk(v, i);
         chk(fullScale, (i == 2 || i == 3) ? 32'h1f4 : 32'h12c);
      end
      chk(calCnt, 6);
      cmd(`HCC_RX_VER, 16'h6); q(`HCC_TX_VER, v); chk(v, 32'h5);
      for (i = 0; i < 4; i = i + 1)
      begin
         cmd(i[3:0], 16'h64 + i[15:0]);
         q(i[3:0], v); chk(v, 32'h64 + i);
      end
      cmd(`HCC_RX_VER, 16'h3); cmd(`HCC_RX_FUNC, `HCC_FN_AUTO_ZERO_CALIBRATION);
      cmd(4'h0, 16'h1c2); // stores 450 under a 500 limit
      cmd(`HCC_RX_VER, 16'h0); cmd(`HCC_RX_FUNC, `HCC_FN_AUTO_ZERO_CALIBRATION);
      cmd(4'h1, 16'hfa); q(4'h1, v); chk(v, 32'h65);
      cmd(`HCC_RX_START, 16'h000a); repeat (3) @(posedge mclk);
      chk(activeSp, 32'hc8);
      cmd(`HCC_RX_START, 16'h0); cmd(`HCC_RX_VER, 16'h1);
      cmd(`HCC_RX_FUNC, `HCC_FN_AUTO_ZERO_CALIBRATION);
      $display("version done");
   end
   endtask
   task t_run;
   begin
      actTemp <= 10'h3fb; inBand <= 1'b1; calBlk <= 1'b1; a0 = ackCnt;
      cmd(`HCC_RX_START, 16'h020a); repeat (3) @(posedge mclk);
      chk(heatOn, 1'b1); calRun <= 1'b1;
      q(`HCC_TX_STATUS, v); chk(v, 32'h6e);
      calRun <= 1'b0;
      cmd(`HCC_RX_START, 16'h0203); rd(`HCC_REG_ACK, d, r);
      // ack carries the state seen as the stop arrives: still in control, in band
      chk(d[15:0], 32'hba05);
      q(`HCC_TX_STATUS, v); chk(v, 32'h22);
      q(`HCC_TX_ACK, v); chk(v, 32'hba05);
      cmd(`HCC_RX_START, 16'h0105); repeat (40) @(posedge mclk);
      q(`HCC_TX_STATUS, v); chk(v, 32'h21);
      chk(ackCnt - a0, 3);
      q(`HCC_TX_ACTUAL, v); chk(v, 32'h8005);
      actTemp <= 10'h0fa; calBlk <= 1'b0;
      q(`HCC_TX_ACTUAL, v); chk(v, 32'hfa);
      $display("run done");
   end
   endtask
   task t_alarm;
   begin
      almCode <= 4'h3;
      cmd(`HCC_RX_START, 16'h000a); repeat (3) @(posedge mclk); chk(heatOn, 1'b0);
      // refused start still acknowledged: pending and refused both set
      rd(`HCC_REG_STAT, d, r); chk(d[3:0], 32'h9);
      almCode <= 4'h0;
      q(`HCC_TX_STATUS, v); chk(v & 32'hfffc, 32'h0310);
      cmd(`HCC_RX_FUNC, `HCC_FN_RESET); rd(`HCC_REG_STAT, d, r); chk(d[1], 1'b1);
      q(`HCC_TX_STATUS, v); chk(v & 32'hfffc, 32'h0);
      cmd(`HCC_RX_START, 16'h000a); repeat (3) @(posedge mclk); chk(heatOn, 1'b0);
      repeat (60) @(posedge mclk);
      cmd(`HCC_RX_START, 16'h000a); repeat (3) @(posedge mclk); chk(heatOn, 1'b1);
      cmd(`HCC_RX_START, 16'h0); wr(`HCC_REG_CTRL, 32'h1, r);
      cmd(`HCC_RX_FUNC, `HCC_FN_RESET); repeat (40) @(posedge mclk);
      q(`HCC_TX_STATUS, v); chk(v & 32'hfffc, 32'h0710);
      energize <= 1'b1;
      cmd(`HCC_RX_FUNC, `HCC_FN_RESET); repeat (40) @(posedge mclk);
      q(`HCC_TX_STATUS, v); chk(v & 32'hfffc, 32'h0);
      repeat (60) @(posedge mclk);
      $display("alarm done");
   end
   endtask
   task t_store;
   begin
      cmd(`HCC_RX_VER, 16'h4); cmd(`HCC_RX_FUNC, `HCC_FN_AUTO_ZERO_CALIBRATION);
      repeat (2) @(posedge mclk);
      @(posedge mclk); nrst <= 1'b0;
      repeat (2) @(posedge mclk); nrst <= 1'b1;
      q(`HCC_TX_VER, v); chk(v, 32'h4);
      chk(fullScale, 32'h12c);
      $display("store done");
   end
   endtask
   task finish_test;
   begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // main sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      t_defaults;
      t_version;
      t_run;
      t_alarm;
      t_store;
      finish_test;
   end
   // watchdog against hangs
   initial
   begin
      repeat (8000) @(posedge mclk);
      n_mismatch = n_mismatch + 1;
      finish_test;
   end
endmodule // tb_top
